// file: hdl/gpib_map.svh
// gpib_map.svh: command codes, address fields and reset values
// assumes inclusion by bare name; definitions only
`ifndef GPIB_MAP_SVH
`define GPIB_MAP_SVH
`define CMD_GROUP_MSB      6
`define CMD_GROUP_LSB      5
`define CMD_ADDR_MSB       4
`define CMD_ADDR_LSB       0
`define GRP_CMD            2'h0
`define GRP_LISTEN         2'h1
`define GRP_TALK           2'h2
`define GRP_SECONDARY      2'h3
`define CMD_GTL            8'h01
`define CMD_SDC            8'h04
`define CMD_PPC            8'h05
`define CMD_GET            8'h08
`define CMD_TCT            8'h09
`define CMD_LLO            8'h11
`define CMD_DCL            8'h14
`define CMD_PPU            8'h15
`define CMD_SPE            8'h18
`define CMD_SPD            8'h19
`define CMD_UNL            8'h3f
`define CMD_UNT            8'h5f
`define ADDR_UNUSED        5'h1f
`define DEFAULT_ADDR       5'h10
`define STB_RQS_BIT        6
`define SETTLE_NS          20
`define CLOCK_NS           4
`define SETTLE_CYCLES      ((`SETTLE_NS + `CLOCK_NS - 1) / `CLOCK_NS)
`define RESET_BYTE         8'h00
`endif

// file: hdl/gpib_pkg.sv
// gpib_pkg: types shared by both ends of the bus
// assumes gpib_map.svh defines the constants
package gpib_pkg;
  typedef enum logic [1:0] {
    SRC_IDLE   = 2'b00,
    SRC_SETTLE = 2'b01,
    SRC_WAIT   = 2'b10,
    SRC_DONE   = 2'b11
  } src_state_t;
  typedef enum logic [1:0] {
    ACC_READY  = 2'b00,
    ACC_HOLD   = 2'b01,
    ACC_WAIT   = 2'b10
  } acc_state_t;
  typedef struct packed {
    src_state_t  state;
    logic [2:0]  count;
    logic [7:0]  data;
    logic        dav;
    logic        done;
  } src_t;
  typedef struct packed {
    acc_state_t  state;
    logic [7:0]  data;
    logic        atn;
    logic        eoi;
    logic        strobe;
    logic        nrfd;
    logic        ndac;
  } acc_t;
endpackage : gpib_pkg

// file: hdl/gpib_bus_if.sv
// gpib_bus_if: the shared bus, wired-or on dio, dav, nrfd, ndac and eoi; atn, ifc, ren and srq have one driver
// assumes an enable high pulls the active-low line true
`timescale 1ns/10ps
interface gpib_bus_if;
  logic [7:0] ctl_dio;
  logic       ctl_dio_oe;
  logic       ctl_dav;
  logic       ctl_nrfd;
  logic       ctl_ndac;
  logic       ctl_atn;
  logic       ctl_eoi;
  logic       ctl_ifc;
  logic       ctl_ren;
  logic [7:0] dev_dio;
  logic       dev_dio_oe;
  logic       dev_dav;
  logic       dev_nrfd;
  logic       dev_ndac;
  logic       dev_eoi;
  logic       dev_srq;
  logic [7:0] dio;
  logic       dav;
  logic       nrfd;
  logic       ndac;
  logic       atn;
  logic       eoi;
  logic       ifc;
  logic       ren;
  logic       srq;
  // lines are modelled asserted-high; open collector gives wired-or
  assign dio  = (ctl_dio_oe ? ctl_dio : 8'h00) |
                (dev_dio_oe ? dev_dio : 8'h00);
  assign dav  = ctl_dav | dev_dav;
  assign nrfd = ctl_nrfd | dev_nrfd;
  assign ndac = ctl_ndac | dev_ndac;
  assign atn  = ctl_atn;
  assign eoi  = ctl_eoi | dev_eoi;
  assign ifc  = ctl_ifc;
  assign ren  = ctl_ren;
  assign srq  = dev_srq;
  modport device (
    output dev_dio, dev_dio_oe, dev_dav, dev_nrfd, dev_ndac, dev_eoi,
           dev_srq,
    input  dio, dav, nrfd, ndac, atn, eoi, ifc, ren
  );
  modport controller (
    output ctl_dio, ctl_dio_oe, ctl_dav, ctl_nrfd, ctl_ndac, ctl_atn,
           ctl_eoi, ctl_ifc, ctl_ren,
    input  dio, dav, nrfd, ndac, eoi, srq
  );
endinterface : gpib_bus_if

// file: hdl/gpib_handshake.sv
// gpib_handshake: three-wire source and acceptor handshake engines
// assumes bus lines already synchronous, modelled asserted-high
`timescale 1ns/10ps
`include "gpib_map.svh"
module gpib_handshake
  import gpib_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       src_en_i,
  input  wire logic       src_req_i,
  input  wire logic [7:0] src_data_i,
  input  wire logic       acc_en_i,
  input  wire logic       acc_free_i,
  input  wire logic [7:0] dio_i,
  input  wire logic       dav_i,
  input  wire logic       nrfd_i,
  input  wire logic       ndac_i,
  input  wire logic       atn_i,
  input  wire logic       eoi_i,
  output logic            src_busy_o,
  output logic            src_done_o,
  output logic [7:0]      src_data_o,
  output logic            src_dav_o,
  output logic            acc_strobe_o,
  output logic [7:0]      acc_data_o,
  output logic            acc_atn_o,
  output logic            acc_eoi_o,
  output logic            acc_nrfd_o,
  output logic            acc_ndac_o
);
  src_t src, next_src;
  acc_t acc, next_acc;
  always_comb begin
    next_src      = src;
    next_src.done = 1'b0;
    case (src.state)
      SRC_IDLE: begin
        if (src_en_i && src_req_i) begin
          next_src.data  = src_data_i;
          next_src.count = 3'(`SETTLE_CYCLES);
          next_src.state = SRC_SETTLE;
        end
      end
      SRC_SETTLE: begin
        // data settles before dav, and only once all are ready
        if (src.count != 3'h0) begin
          next_src.count = src.count - 3'h1;
        end else if (!nrfd_i) begin
          next_src.dav   = 1'b1;
          next_src.state = SRC_WAIT;
        end
      end
      SRC_WAIT: begin
        if (!ndac_i) begin
          next_src.dav   = 1'b0;
          next_src.done  = 1'b1;
          next_src.state = SRC_DONE;
        end
      end
      SRC_DONE:
        next_src.state = SRC_IDLE;
      default:
        next_src.state = SRC_IDLE;
    endcase
    // losing the talk role aborts mid-byte rather than hang the bus
    if (!src_en_i) begin
      next_src.state = SRC_IDLE;
      next_src.dav   = 1'b0;
    end
  end
  always_comb begin
    next_acc        = acc;
    next_acc.strobe = 1'b0;
    case (acc.state)
      ACC_READY: begin
        next_acc.ndac = 1'b1;
        next_acc.nrfd = !acc_free_i;
        // first enabled cycle only raises ndac; a byte already valid then
        // is not half-taken
        if (dav_i && !acc.nrfd && acc.ndac) begin
          next_acc.data   = dio_i;
          next_acc.atn    = atn_i;
          next_acc.eoi    = eoi_i;
          next_acc.strobe = 1'b1;
          next_acc.nrfd   = 1'b1;
          next_acc.state  = ACC_HOLD;
        end
      end
      ACC_HOLD: begin
        next_acc.ndac  = 1'b0;
        next_acc.state = ACC_WAIT;
      end
      ACC_WAIT: begin
        if (!dav_i) begin
          next_acc.ndac  = 1'b1;
          next_acc.state = ACC_READY;
        end
      end
      default:
        next_acc.state = ACC_READY;
    endcase
    // an idle acceptor stays off the handshake lines entirely
    if (!acc_en_i) begin
      next_acc.state = ACC_READY;
      next_acc.nrfd  = 1'b0;
      next_acc.ndac  = 1'b0;
    end
  end
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      src <= '0;
      acc <= '0;
    end else begin
      src <= next_src;
      acc <= next_acc;
    end
  end
  assign src_busy_o   = src.state != SRC_IDLE;
  assign src_done_o   = src.done;
  assign src_data_o   = src.data;
  assign src_dav_o    = src.dav;
  assign acc_strobe_o = acc.strobe;
  assign acc_data_o   = acc.data;
  assign acc_atn_o    = acc.atn;
  assign acc_eoi_o    = acc.eoi;
  assign acc_nrfd_o   = acc.nrfd;
  assign acc_ndac_o   = acc.ndac;
endmodule : gpib_handshake

// file: hdl/gpib_device.sv
// gpib_device: instrument end of the bus, talker, listener and friends
// assumes bus lines synchronous to clock_i; address fixed by caller
`timescale 1ns/10ps
`include "gpib_map.svh"
module gpib_device
  import gpib_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  gpib_bus_if.device      bus,
  input  wire logic [4:0] address_i,
  input  wire logic       talk_only_i,
  input  wire logic       service_req_i,
  input  wire logic [7:0] status_i,
  input  wire logic       out_valid_i,
  input  wire logic [7:0] out_data_i,
  input  wire logic       out_last_i,
  output logic            out_taken_o,
  output logic            in_valid_o,
  output logic [7:0]      in_data_o,
  output logic            in_end_o,
  output logic            dev_clear_o,
  output logic            trigger_o,
  output logic            remote_o,
  output logic            talker_o,
  output logic            listener_o
);
  typedef struct packed {
    logic       talk;
    logic       listen;
    logic       poll_mode;
    logic       remote;
    logic       lockout;
    logic       srq;
    logic       in_valid;
    logic [7:0] in_data;
    logic       in_end;
    logic       clear;
    logic       trig;
    logic       taken;
    logic       eoi;
  } dev_t;
  dev_t st, next_st;
  logic       src_busy;
  logic       src_done;
  logic [7:0] src_data;
  logic       src_dav;
  logic       acc_strobe;
  logic [7:0] acc_data;
  logic       acc_atn;
  logic       acc_eoi;
  logic       acc_nrfd;
  logic       acc_ndac;
  logic       src_en;
  logic [7:0] tx_byte;
  logic       tx_req;
  function automatic logic is_addr(input logic [7:0] b,
                                   input logic [1:0] grp,
                                   input logic [4:0] a);
    is_addr = b[`CMD_GROUP_MSB:`CMD_GROUP_LSB] == grp &&
              b[`CMD_ADDR_MSB:`CMD_ADDR_LSB] == a;
  endfunction : is_addr
  // talker sources while attention is off; poll sends the status byte
  assign src_en = (st.talk || talk_only_i) && !bus.atn && !bus.ifc;
  assign tx_byte = st.poll_mode ?
                   {status_i[7], st.srq, status_i[5:0]} : out_data_i;
  assign tx_req  = st.poll_mode || out_valid_i;
  gpib_handshake u_hs (
    .clock_i      (clock_i),
    .rst_i        (rst_i),
    .src_en_i     (src_en),
    .src_req_i    (tx_req),
    .src_data_i   (tx_byte),
    // acceptor joins only as listener or for commands
    .acc_en_i     ((st.listen || bus.atn) && !talk_only_i && !bus.ifc),
    .acc_free_i   (!st.in_valid),
    .dio_i        (bus.dio),
    .dav_i        (bus.dav),
    .nrfd_i       (bus.nrfd),
    .ndac_i       (bus.ndac),
    .atn_i        (bus.atn),
    .eoi_i        (bus.eoi),
    .src_busy_o   (src_busy),
    .src_done_o   (src_done),
    .src_data_o   (src_data),
    .src_dav_o    (src_dav),
    .acc_strobe_o (acc_strobe),
    .acc_data_o   (acc_data),
    .acc_atn_o    (acc_atn),
    .acc_eoi_o    (acc_eoi),
    .acc_nrfd_o   (acc_nrfd),
    .acc_ndac_o   (acc_ndac)
  );
  always_comb begin
    next_st          = st;
    next_st.in_valid = 1'b0;
    next_st.clear    = 1'b0;
    next_st.trig     = 1'b0;
    next_st.taken    = 1'b0;
    next_st.srq      = service_req_i && !st.poll_mode ? 1'b1 : st.srq;
    if (acc_strobe && acc_atn) begin
      // every byte under attention is an interface command
      if (is_addr(acc_data, `GRP_LISTEN, address_i)) begin
        next_st.listen = 1'b1;
        next_st.talk   = 1'b0;
      end else if (acc_data == `CMD_UNL) begin
        next_st.listen = 1'b0;
      end else if (is_addr(acc_data, `GRP_TALK, address_i)) begin
        next_st.talk   = 1'b1;
        next_st.listen = 1'b0;
      end else if (acc_data[`CMD_GROUP_MSB:`CMD_GROUP_LSB] == `GRP_TALK) begin
        next_st.talk = 1'b0;
      end else if (acc_data[`CMD_GROUP_MSB:`CMD_GROUP_LSB] == `GRP_SECONDARY) begin
        next_st.talk = st.talk;
      end else begin
        case (acc_data)
          `CMD_DCL:
            next_st.clear = 1'b1;
          `CMD_SDC:
            next_st.clear = st.listen;
          `CMD_GET:
            next_st.trig = st.listen;
          `CMD_GTL:
            next_st.remote = st.listen ? 1'b0 : st.remote;
          `CMD_LLO:
            next_st.lockout = 1'b1;
          `CMD_SPE:
            next_st.poll_mode = 1'b1;
          `CMD_SPD:
            next_st.poll_mode = 1'b0;
          `CMD_PPC, `CMD_PPU:
            next_st.poll_mode = st.poll_mode;
          default:
            next_st.poll_mode = st.poll_mode;
        endcase
      end
    end else if (acc_strobe && st.listen) begin
      next_st.in_valid = 1'b1;
      next_st.in_data  = acc_data;
      next_st.in_end   = acc_eoi;
    end
    // remote follows enable; listen addressing with enable goes remote
    if (!bus.ren) begin
      next_st.remote  = 1'b0;
      next_st.lockout = 1'b0;
    end else if (acc_strobe && acc_atn &&
                 is_addr(acc_data, `GRP_LISTEN, address_i)) begin
      next_st.remote = 1'b1;
    end
    if (src_done) begin
      if (st.poll_mode) begin
        next_st.srq = service_req_i; // rqs reloads from service_req_i once polled
      end else begin
        next_st.taken = 1'b1;
      end
    end
    next_st.eoi = src_busy && !st.poll_mode && out_last_i;
    if (talk_only_i) begin
      next_st.talk = 1'b1;
    end
    if (bus.ifc) begin
      next_st.talk      = 1'b0;
      next_st.listen    = 1'b0;
      next_st.poll_mode = 1'b0;
    end
  end
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  // attention, clear and enable have no driver here at all
  assign bus.dev_dio    = src_data;
  assign bus.dev_dio_oe = src_busy;
  assign bus.dev_dav    = src_dav;
  assign bus.dev_nrfd   = acc_nrfd;
  assign bus.dev_ndac   = acc_ndac;
  assign bus.dev_eoi    = st.eoi;
  assign bus.dev_srq    = st.srq;
  assign out_taken_o    = st.taken;
  assign in_valid_o     = st.in_valid;
  assign in_data_o      = st.in_data;
  assign in_end_o       = st.in_end;
  assign dev_clear_o    = st.clear;
  assign trigger_o      = st.trig;
  assign remote_o       = st.remote;
  assign talker_o       = st.talk;
  assign listener_o     = st.listen;
endmodule : gpib_device

// file: hdl/gpib_controller.sv
// gpib_controller: bus controller end, sends commands and data bytes
// assumes one request at a time from the user side
`timescale 1ns/10ps
`include "gpib_map.svh"
module gpib_controller
  import gpib_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  gpib_bus_if.controller  bus,
  input  wire logic       send_i,
  input  wire logic [7:0] send_data_i,
  input  wire logic       send_atn_i,
  input  wire logic       send_eoi_i,
  input  wire logic       listen_i,
  input  wire logic       ifc_i,
  input  wire logic       ren_i,
  output logic            send_done_o,
  output logic            busy_o,
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  output logic            rx_end_o,
  output logic            srq_o
);
  typedef struct packed {
    logic atn;
    logic eoi;
    logic ifc;
    logic ren;
    logic srq;
  } ctl_t;
  ctl_t c, next_c;
  logic       src_busy;
  logic       src_done;
  logic [7:0] src_data;
  logic       src_dav;
  logic       acc_strobe;
  logic [7:0] acc_data;
  logic       acc_eoi;
  logic       acc_nrfd;
  logic       acc_ndac;
  // listening is only legal with attention off, so it gates the source
  gpib_handshake u_hs (
    .clock_i      (clock_i),
    .rst_i        (rst_i),
    .src_en_i     (!listen_i),
    .src_req_i    (send_i),
    .src_data_i   (send_data_i),
    .acc_en_i     (listen_i && !c.atn),
    .acc_free_i   (1'b1),
    .dio_i        (bus.dio),
    .dav_i        (bus.dav),
    .nrfd_i       (bus.nrfd),
    .ndac_i       (bus.ndac),
    .atn_i        (1'b0),
    .eoi_i        (bus.eoi),
    .src_busy_o   (src_busy),
    .src_done_o   (src_done),
    .src_data_o   (src_data),
    .src_dav_o    (src_dav),
    .acc_strobe_o (acc_strobe),
    .acc_data_o   (acc_data),
    .acc_atn_o    (),
    .acc_eoi_o    (acc_eoi),
    .acc_nrfd_o   (acc_nrfd),
    .acc_ndac_o   (acc_ndac)
  );
  always_comb begin
    next_c     = c;
    next_c.ifc = ifc_i;
    next_c.ren = ren_i;
    next_c.srq = bus.srq;
    // attention latched with the byte and held through the handshake
    if (send_i && !src_busy && !listen_i) begin
      next_c.atn = send_atn_i;
      next_c.eoi = send_eoi_i && !send_atn_i;
    end
    // a talker cannot source while attention stays on
    if (listen_i) begin
      next_c.atn = 1'b0;
    end
  end
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      c <= '0;
    end else begin
      c <= next_c;
    end
  end
  assign bus.ctl_dio    = src_data;
  assign bus.ctl_dio_oe = src_busy;
  assign bus.ctl_dav    = src_dav;
  assign bus.ctl_nrfd   = acc_nrfd;
  assign bus.ctl_ndac   = acc_ndac;
  assign bus.ctl_atn    = c.atn;
  assign bus.ctl_eoi    = c.eoi && src_busy;
  assign bus.ctl_ifc    = c.ifc;
  assign bus.ctl_ren    = c.ren;
  assign send_done_o    = src_done;
  assign busy_o         = src_busy;
  assign rx_valid_o     = acc_strobe;
  assign rx_data_o      = acc_data;
  assign rx_end_o       = acc_eoi;
  assign srq_o          = c.srq;
endmodule : gpib_controller

// file: verification/gpib_bus_sva.sv
// gpib_bus_sva: timing checks on the shared bus between the two ends
// assumes signals come straight from gpib_bus_if, asserted-high lines
`timescale 1ns/10ps
module gpib_bus_sva (
  input logic       clock_i,
  input logic       rst_i,
  input logic [7:0] dio,
  input logic       dav,
  input logic       nrfd,
  input logic       ndac,
  input logic       atn,
  input logic       ifc,
  input logic       srq,
  input logic       dev_dio_oe,
  input logic       dev_dav,
  input logic       dev_ndac
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  AST_DIO_STABLE: assert property (dav && $past(dav) |-> $stable(dio))
    else $error("data changed while valid");
  AST_DAV_AFTER_READY: assert property ($rose(dav) |-> !$past(nrfd))
    else $error("valid raised while not ready");
  // interface clear may abort a transfer, so it is excluded here
  AST_DAV_HELD: assert property (disable iff (rst_i || ifc)
    $fell(dav) |-> !$past(ndac))
    else $error("valid dropped before accept");
  AST_NO_TALK_UNDER_ATN: assert property (
    atn && $past(atn) |-> !dev_dio_oe)
    else $error("device drives data under attention");
  AST_SRC_DRIVES_DATA: assert property (dev_dav |-> dev_dio_oe)
    else $error("device valid without data drive");
  AST_TALKER_NOT_ACCEPTOR: assert property (dev_dav |-> !dev_ndac)
    else $error("device accepts its own byte");
  AST_CMD_ACCEPT: assert property (
    $rose(dav) && atn |-> dev_ndac ##[1:8] !dev_ndac)
    else $error("command byte not accepted in time");
  AST_IFC_DROPS_SOURCE: assert property (
    $rose(ifc) |-> ##[0:2] !dev_dav)
    else $error("source kept running after clear");

  cover property ($rose(dev_dav));
  cover property ($rose(dav) && atn);
  cover property ($rose(srq));
  cover property ($rose(ifc));
endmodule : gpib_bus_sva

// file: verification/testbench.sv
// testbench: controller end and device end joined over one bus
// assumes device at primary address 16, single 250 MHz clock
`timescale 1ns/10ps
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
  fails++; $display("ERROR %0t: got %h exp %h", $time, got, exp); end end
module testbench;
  import gpib_pkg::*;
  logic       clock_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       talk_only_i = 1'b0;
  logic       service_req_i = 1'b0;
  logic [7:0] status_i = 8'h05;
  logic       out_valid_i = 1'b0;
  logic [7:0] out_data_i = 8'h00;
  logic       out_last_i = 1'b0;
  logic       send_i = 1'b0;
  logic [7:0] send_data_i = 8'h00;
  logic       send_atn_i = 1'b0;
  logic       send_eoi_i = 1'b0;
  logic       listen_i = 1'b0;
  logic       ifc_i = 1'b0;
  logic       ren_i = 1'b0;
  logic       out_taken_o, in_valid_o, in_end_o, dev_clear_o, trigger_o;
  logic       remote_o, talker_o, listener_o;
  logic [7:0] in_data_o, rx_data_o;
  logic       send_done_o, busy_o, rx_valid_o, rx_end_o, srq_o;
  logic [8:0] dev_rx[$];
  logic [8:0] ctl_rx[$];
  logic [8:0] msg[4] = '{9'h02a, 9'h052, 9'h053, 9'h154};
  int         fails = 0;
  int         cmp_count = 0;
  int         clr_n = 0;
  int         trg_n = 0;

  gpib_bus_if bus ();
  gpib_device gpib_device_i (.clock_i(clock_i), .rst_i(rst_i), .bus(bus),
    .address_i(5'h10), .talk_only_i(talk_only_i),
    .service_req_i(service_req_i), .status_i(status_i),
    .out_valid_i(out_valid_i), .out_data_i(out_data_i),
    .out_last_i(out_last_i), .out_taken_o(out_taken_o),
    .in_valid_o(in_valid_o), .in_data_o(in_data_o), .in_end_o(in_end_o),
    .dev_clear_o(dev_clear_o), .trigger_o(trigger_o), .remote_o(remote_o),
    .talker_o(talker_o), .listener_o(listener_o));
  gpib_controller gpib_controller_i (.clock_i(clock_i), .rst_i(rst_i),
    .bus(bus), .send_i(send_i), .send_data_i(send_data_i),
    .send_atn_i(send_atn_i), .send_eoi_i(send_eoi_i), .listen_i(listen_i),
    .ifc_i(ifc_i), .ren_i(ren_i), .send_done_o(send_done_o),
    .busy_o(busy_o), .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o),
    .rx_end_o(rx_end_o), .srq_o(srq_o));
  gpib_bus_sva gpib_bus_sva_i (.clock_i(clock_i), .rst_i(rst_i),
    .dio(bus.dio), .dav(bus.dav), .nrfd(bus.nrfd), .ndac(bus.ndac),
    .atn(bus.atn), .ifc(bus.ifc), .srq(bus.srq),
    .dev_dio_oe(bus.dev_dio_oe), .dev_dav(bus.dev_dav),
    .dev_ndac(bus.dev_ndac));

  initial begin
    forever #2 clock_i = ~clock_i;
  end

  // pulses are sampled one edge after they were launched
  always @(posedge clock_i) begin
    if (in_valid_o === 1'b1) dev_rx.push_back({in_end_o, in_data_o});
    if (rx_valid_o === 1'b1) ctl_rx.push_back({rx_end_o, rx_data_o});
    if (dev_clear_o === 1'b1) clr_n++;
    if (trigger_o === 1'b1) trg_n++;
  end

  task automatic tally_and_finish();
    $display("TB: %0d compares, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask : wait_cyc

  // one bus byte from the controller; three gap cycles keep strobes apart
  task automatic send(input logic [7:0] d, input logic a, input logic e);
    int n;
    n = 0;
    send_data_i = d;
    send_atn_i = a;
    send_eoi_i = e;
    send_i = 1'b1;
    do begin
      @(negedge clock_i);
      n++;
    end while (send_done_o !== 1'b1 && n < 200);
    send_i = 1'b0;
    if (n >= 200) begin
      fails++;
      $display("ERROR %0t: send timeout", $time);
    end
    wait_cyc(3);
  endtask : send

  task automatic dev_out(input logic [7:0] d, input logic last);
    int n;
    n = 0;
    out_data_i = d;
    out_last_i = last;
    out_valid_i = 1'b1;
    do begin
      @(negedge clock_i);
      n++;
    end while (out_taken_o !== 1'b1 && n < 200);
    out_valid_i = 1'b0;
    if (n >= 200) begin
      fails++;
      $display("ERROR %0t: dev_out timeout", $time);
    end
    wait_cyc(1);
  endtask : dev_out

  task automatic wait_rx(input int k);
    int n;
    n = 0;
    while (ctl_rx.size() < k && n < 300) begin
      @(negedge clock_i);
      n++;
    end
    `CHECK(ctl_rx.size(), k)
  endtask : wait_rx

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test

  initial begin
    repeat (20000) @(posedge clock_i);
    fails++;
    $display("ERROR %0t: watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge clock_i);
    @(negedge clock_i);
    rst_i = 1'b0;
    ren_i = 1'b1;
    send(8'h3f, 1'b1, 1'b0);
    send(8'h30, 1'b1, 1'b0);
    send(8'h04, 1'b1, 1'b0);
    `CHECK(listener_o, 1'b1)
    `CHECK(clr_n, 1)
    `CHECK(remote_o, 1'b1)
    end_test("addressed clear");
    foreach (msg[i]) send(msg[i][7:0], 1'b0, msg[i][8]);
    `CHECK(dev_rx.size(), 4)
    foreach (msg[i]) `CHECK(dev_rx[i], msg[i])
    dev_rx.delete();
    end_test("device data");
    send(8'h3f, 1'b1, 1'b0);
    send(8'h41, 1'b0, 1'b0);
    send(8'h04, 1'b1, 1'b0);
    send(8'h08, 1'b1, 1'b0);
    `CHECK(listener_o, 1'b0)
    `CHECK(dev_rx.size(), 0)
    `CHECK(clr_n, 1)
    `CHECK(trg_n, 0)
    end_test("unaddressed");
    send(8'h30, 1'b1, 1'b0);
    send(8'h05, 1'b1, 1'b0);
    send(8'h15, 1'b1, 1'b0);
    send(8'h70, 1'b1, 1'b0);
    `CHECK(listener_o, 1'b1)
    `CHECK(talker_o, 1'b0)
    send(8'h08, 1'b1, 1'b0);
    `CHECK(trg_n, 1)
    send(8'h01, 1'b1, 1'b0);
    `CHECK(remote_o, 1'b0)
    end_test("ignored and trigger");
    send(8'h50, 1'b1, 1'b0);
    `CHECK(talker_o, 1'b1)
    `CHECK(listener_o, 1'b0)
    listen_i = 1'b1;
    dev_out(8'ha5, 1'b0);
    dev_out(8'h3c, 1'b1);
    wait_rx(2);
    `CHECK(ctl_rx[0], 9'h0a5)
    `CHECK(ctl_rx[1], 9'h13c)
    listen_i = 1'b0;
    wait_cyc(2);
    send(8'h30, 1'b1, 1'b0);
    `CHECK(talker_o, 1'b0)
    end_test("talker");
    ctl_rx.delete();
    service_req_i = 1'b1;
    wait_cyc(4);
    `CHECK(srq_o, 1'b1)
    send(8'h18, 1'b1, 1'b0);
    send(8'h50, 1'b1, 1'b0);
    listen_i = 1'b1;
    wait_rx(1);
    `CHECK(ctl_rx[0][7:0], 8'h45)
    listen_i = 1'b0;
    service_req_i = 1'b0;
    wait_cyc(2);
    send(8'h19, 1'b1, 1'b0);
    end_test("serial poll");
    send(8'h3f, 1'b1, 1'b0);
    send(8'h14, 1'b1, 1'b0);
    `CHECK(clr_n, 2)
    send(8'h30, 1'b1, 1'b0);
    ifc_i = 1'b1;
    wait_cyc(4);
    ifc_i = 1'b0;
    wait_cyc(3);
    `CHECK(listener_o, 1'b0)
    `CHECK(talker_o, 1'b0)
    end_test("clears");
    ctl_rx.delete();
    talk_only_i = 1'b1;
    wait_cyc(3);
    `CHECK(talker_o, 1'b1)
    listen_i = 1'b1;
    dev_out(8'h66, 1'b1);
    wait_rx(1);
    `CHECK(ctl_rx[0], 9'h166)
    end_test("talk only");
    tally_and_finish();
  end
endmodule : testbench
